// [logic/dtd_edge_sync.sv]
// pin synchroniser with rising and falling edge pulses
// assumes i_pin is asynchronous to i_clk
module dtd_edge_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // pin
  input  wire logic i_pin,
  // edge pulses
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_reg;  // first stage, read only by the second
  logic sync_reg;  // second stage
  logic prev_reg;  // delayed copy for edge detection

  // two flip-flop synchroniser plus history
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // one-cycle edge pulses
  assign o_rise = sync_reg & ~prev_reg;
  assign o_fall = ~sync_reg & prev_reg;

endmodule // dtd_edge_sync

// [logic/dtd_timer_top.sv]
// byte and word counter/timers with demodulation capture
// assumes cpu register-file access in the same clock domain, pins asynchronous
//
// Function
// - timer registers live in expanded bank d
// - short addresses use sixteen-register pointer groups
// - bank zero: ports, general, control regions
// - writing one starts the byte timer
// - byte timer reloads or halts at terminal
// - timeout flag set; cleared only by one
// - first byte tick is unaligned to enable
// - word run bit reads state, writes start/stop
// - word timer reloads or stops at terminal
// - word bit six gates demodulation edges
// - word prescale divides clock by 1,2,4,8
// - word capture and timeout interrupt enables
// - power-on clears all; recovery keeps marked fields
// - zero to ff wrap is no timeout
// - stop lands one counter tick after write
// - byte demod count starts at first edge
// - later edges capture complemented count
// - edge select fall, rise, both, reserved
module dtd_timer_top import dtd_pkg::*; #(
  parameter int BYTE_W = 8,   // byte timer width
  parameter int WORD_W = 16   // word timer width
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_stop_recover,
  // cpu register file access
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_short_addr,
  input  wire logic [7:0]  i_register_pointer,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_hit,
  output logic      [1:0]  o_region,
  // demodulator pins
  input  wire logic        i_demod_pin_a,
  input  wire logic        i_demod_pin_b,
  // timer outputs
  output logic             o_byte_timer_out,
  output logic             o_word_timer_out,
  output logic             o_byte_timer_pin_select,
  output logic             o_word_timer_pin_select,
  output logic             o_timeout_irq,
  output logic             o_capture_irq
);

  // prescaler tick for a divide code
  function automatic logic tick_of(input logic [1:0] code, input logic [2:0] cnt);
    case (code)
      2'h0:    tick_of = 1'b1;
      2'h1:    tick_of = cnt[0];
      2'h2:    tick_of = &cnt[1:0];
      default: tick_of = &cnt;
    endcase
  endfunction

  // address decode
  logic [7:0]  eff_addr;     // effective register address
  logic [3:0]  off;          // offset inside timer bank
  logic        hit;          // access lands on timer bank
  logic        wr;           // write to timer bank
  // byte timer control fields
  logic        b_run_reg, b_single_reg, b_tout_reg, b_cap_mask_reg, b_tout_mask_reg, b_pin_reg;
  logic [1:0]  b_clk_reg;
  // shared control fields
  logic        mode_reg, insel_reg, rise_flag_reg, fall_flag_reg;
  logic [1:0]  edge_sel_reg, logic_reg;
  // word timer control fields
  logic        w_run_reg, w_single_reg, w_tout_reg, w_cap_mask_reg, w_tout_mask_reg, w_pin_reg;
  logic [1:0]  w_clk_reg;
  // data registers
  logic [BYTE_W-1:0] b_init_lo_reg, b_init_hi_reg, cap_rise_reg, cap_fall_reg, b_cnt_reg;
  logic [WORD_W-1:0] w_init_reg, w_cnt_reg;
  // timer state
  logic [2:0]  presc_reg;    // free-running prescaler
  logic        b_stop_reg;   // byte stop pending
  logic        w_stop_reg;   // word stop pending
  logic        b_phase_reg;  // byte reload phase, high init next
  logic        b_out_reg, w_out_reg;
  dtd_demod_t  b_state_reg;
  // events
  logic        b_tick, w_tick, pin_rise, pin_fall, qual_edge;
  logic        b_tc, w_tc, cap_evt, b_start, w_start;

  // working group and bank selection from the pointer
  assign eff_addr = i_short_addr ? {i_register_pointer[7:4], i_reg_addr[3:0]} : i_reg_addr;
  assign hit      = (eff_addr[7:4] == DTD_MAIN_BANK) &&
                    (i_register_pointer[3:0] == DTD_TIMER_BANK);
  assign off      = eff_addr[3:0];
  assign wr       = i_reg_wr & hit;
  assign o_reg_hit = hit;

  // region classification of bank zero
  always_comb begin
    if (hit)                            o_region = DTD_RGN_TIMER;
    else if (eff_addr <= DTD_PORT_LAST) o_region = DTD_RGN_PORT;
    else if (eff_addr <= DTD_GP_LAST)   o_region = DTD_RGN_GP;
    else                                o_region = DTD_RGN_CTRL;
  end

  // start strobes
  assign b_start = wr && off == DTD_OFF_BCTL && i_reg_wdata[DTD_B_RUN];
  assign w_start = wr && off == DTD_OFF_WCTL && i_reg_wdata[DTD_B_RUN];

  // free prescaler, so the first tick after enable is unaligned
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) presc_reg <= DTD_RST_PRESC;
    else           presc_reg <= presc_reg + 3'h1;
  end

  assign b_tick = tick_of(b_clk_reg, presc_reg);
  assign w_tick = tick_of(w_clk_reg, presc_reg);

  // demodulator input synchroniser
  dtd_edge_sync u_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (insel_reg ? i_demod_pin_b : i_demod_pin_a),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  // edge qualification by select code, reserved code ignores all
  always_comb begin
    case (edge_sel_reg)
      DTD_EDGE_FALL: qual_edge = pin_fall;
      DTD_EDGE_RISE: qual_edge = pin_rise;
      DTD_EDGE_BOTH: qual_edge = pin_rise | pin_fall;
      default:       qual_edge = 1'b0;
    endcase
  end

  // terminal count events; demod wrap of byte timer is not one
  assign b_tc    = b_run_reg && !mode_reg && b_tick && b_cnt_reg == '0;
  assign w_tc    = w_run_reg && w_tick && w_cnt_reg == '0;
  assign cap_evt = b_run_reg && mode_reg && b_state_reg == DTD_COUNT && qual_edge;

  // byte timer control register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      b_run_reg <= 1'b0; b_single_reg <= 1'b0; b_pin_reg <= 1'b0;
      b_clk_reg <= 2'h0; b_cap_mask_reg <= 1'b0; b_tout_mask_reg <= 1'b0;
      b_stop_reg <= 1'b0;
    end else if (i_stop_recover) begin
      b_run_reg <= 1'b0; b_single_reg <= 1'b0; b_pin_reg <= 1'b0;
      b_stop_reg <= 1'b0;
    end else begin
      if (wr && off == DTD_OFF_BCTL) begin
        b_single_reg    <= i_reg_wdata[DTD_B_SINGLE];
        b_clk_reg       <= i_reg_wdata[DTD_B_CLK_HI:DTD_B_CLK_LO];
        b_cap_mask_reg  <= i_reg_wdata[DTD_B_CAP_MASK];
        b_tout_mask_reg <= i_reg_wdata[DTD_B_TOUT_MASK];
        b_pin_reg       <= i_reg_wdata[DTD_B_PIN];
      end
      if (b_start) begin
        b_run_reg  <= 1'b1;
        b_stop_reg <= 1'b0;
      end else if (wr && off == DTD_OFF_BCTL && b_run_reg) begin
        b_stop_reg <= 1'b1;
      end else if (b_stop_reg && b_tick) begin
        b_run_reg  <= 1'b0;
        b_stop_reg <= 1'b0;
      end else if (b_tc && b_single_reg) begin
        b_run_reg  <= 1'b0;
      end
    end
  end

  // word timer control register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      w_run_reg <= 1'b0; w_single_reg <= 1'b0; w_pin_reg <= 1'b0;
      w_clk_reg <= 2'h0; w_cap_mask_reg <= 1'b0; w_tout_mask_reg <= 1'b0;
      w_stop_reg <= 1'b0;
    end else if (i_stop_recover) begin
      w_run_reg <= 1'b0; w_single_reg <= 1'b0; w_pin_reg <= 1'b0;
      w_tout_mask_reg <= 1'b0; w_stop_reg <= 1'b0;
    end else begin
      if (wr && off == DTD_OFF_WCTL) begin
        w_single_reg    <= i_reg_wdata[DTD_B_SINGLE];
        w_clk_reg       <= i_reg_wdata[DTD_B_CLK_HI:DTD_B_CLK_LO];
        w_cap_mask_reg  <= i_reg_wdata[DTD_B_CAP_MASK];
        w_tout_mask_reg <= i_reg_wdata[DTD_B_TOUT_MASK];
        w_pin_reg       <= i_reg_wdata[DTD_B_PIN];
      end
      if (w_start) begin
        w_run_reg  <= 1'b1;
        w_stop_reg <= 1'b0;
      end else if (wr && off == DTD_OFF_WCTL && w_run_reg) begin
        w_stop_reg <= 1'b1;
      end else if (w_stop_reg && w_tick) begin
        w_run_reg  <= 1'b0;
        w_stop_reg <= 1'b0;
      end else if (w_tc && w_single_reg && !mode_reg) begin
        w_run_reg  <= 1'b0;
      end
    end
  end

  // shared control and write-one-to-clear edge flags
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_stop_recover) begin
      mode_reg <= 1'b0; insel_reg <= 1'b0; edge_sel_reg <= 2'h0; logic_reg <= 2'h0;
      rise_flag_reg <= 1'b0; fall_flag_reg <= 1'b0;
    end else begin
      if (wr && off == DTD_OFF_SCTL) begin
        mode_reg     <= i_reg_wdata[DTD_S_MODE];
        insel_reg    <= i_reg_wdata[DTD_S_INSEL];
        edge_sel_reg <= i_reg_wdata[DTD_S_EDGE_HI:DTD_S_EDGE_LO];
        logic_reg    <= i_reg_wdata[DTD_S_LOGIC_HI:DTD_S_LOGIC_LO];
      end
      // capture sets win over a same-cycle clear
      if (cap_evt && pin_rise)
        rise_flag_reg <= 1'b1;
      else if (wr && off == DTD_OFF_SCTL && i_reg_wdata[DTD_S_RISE])
        rise_flag_reg <= 1'b0;
      if (cap_evt && pin_fall)
        fall_flag_reg <= 1'b1;
      else if (wr && off == DTD_OFF_SCTL && i_reg_wdata[DTD_S_FALL])
        fall_flag_reg <= 1'b0;
    end
  end

  // timeout flags, set wins, cleared only by writing one
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_stop_recover) begin
      b_tout_reg <= 1'b0;
      w_tout_reg <= 1'b0;
    end else begin
      if (b_tc)
        b_tout_reg <= 1'b1;
      else if (wr && off == DTD_OFF_BCTL && i_reg_wdata[DTD_B_TOUT])
        b_tout_reg <= 1'b0;
      if (w_tc)
        w_tout_reg <= 1'b1;
      else if (wr && off == DTD_OFF_WCTL && i_reg_wdata[DTD_B_TOUT])
        w_tout_reg <= 1'b0;
    end
  end

  // initial value registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      b_init_lo_reg <= '0;
      b_init_hi_reg <= '0;
      w_init_reg    <= '0;
    end else if (wr) begin
      case (off)
        DTD_OFF_BINIT_LO: b_init_lo_reg <= i_reg_wdata[BYTE_W-1:0];
        DTD_OFF_BINIT_HI: b_init_hi_reg <= i_reg_wdata[BYTE_W-1:0];
        DTD_OFF_WINIT_LO: w_init_reg[7:0]  <= i_reg_wdata;
        DTD_OFF_WINIT_HI: w_init_reg[15:8] <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // byte counter: transmit reload/halt, demod arm, count and wrap
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_stop_recover) begin
      b_cnt_reg   <= '0;
      b_phase_reg <= 1'b0;
      b_out_reg   <= 1'b0;
      b_state_reg <= DTD_IDLE;
    end else if (b_start) begin
      b_cnt_reg   <= b_init_lo_reg;
      b_phase_reg <= 1'b1;
      b_out_reg   <= rise_flag_reg;                    // initial output level in transmit
      b_state_reg <= mode_reg ? DTD_ARMED : DTD_IDLE;
    end else if (!b_run_reg) begin
      b_state_reg <= DTD_IDLE;
    end else if (mode_reg) begin
      case (b_state_reg)
        DTD_ARMED: if (qual_edge) begin
          b_cnt_reg   <= b_init_lo_reg;
          b_state_reg <= DTD_COUNT;
        end
        DTD_COUNT: if (b_tick)
          b_cnt_reg <= b_cnt_reg - 1'b1;
        default: b_state_reg <= DTD_ARMED;
      endcase
    end else if (b_tc) begin
      if (!b_single_reg) begin
        b_cnt_reg   <= b_phase_reg ? b_init_hi_reg : b_init_lo_reg;
        b_phase_reg <= ~b_phase_reg;
      end
      b_out_reg <= ~b_out_reg;
    end else if (b_tick) begin
      b_cnt_reg <= b_cnt_reg - 1'b1;
    end
  end

  // complemented count captured by edge polarity
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cap_rise_reg <= '0;
      cap_fall_reg <= '0;
    end else if (cap_evt) begin
      if (pin_rise) cap_rise_reg <= ~b_cnt_reg;
      if (pin_fall) cap_fall_reg <= ~b_cnt_reg;
    end
  end

  // word counter: reload or stop, demod edges restart
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_stop_recover) begin
      w_cnt_reg <= '0;
      w_out_reg <= 1'b0;
    end else if (w_start) begin
      w_cnt_reg <= w_init_reg;
      w_out_reg <= fall_flag_reg;                      // initial output level in transmit
    end else if (w_run_reg && mode_reg && !w_single_reg && qual_edge) begin
      w_cnt_reg <= w_init_reg;
    end else if (w_tc) begin
      if (!w_single_reg || mode_reg)
        w_cnt_reg <= w_init_reg;
      w_out_reg <= ~w_out_reg;
    end else if (w_run_reg && w_tick) begin
      w_cnt_reg <= w_cnt_reg - 1'b1;
    end
  end

  // registered read data
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= DTD_RST_BYTE;
    end else if (!hit) begin
      o_reg_rdata <= DTD_RST_BYTE;
    end else begin
      case (off)
        DTD_OFF_BCTL:     o_reg_rdata <= {b_run_reg, b_single_reg, b_tout_reg, b_clk_reg,
                                          b_cap_mask_reg, b_tout_mask_reg, b_pin_reg};
        DTD_OFF_SCTL:     o_reg_rdata <= {mode_reg, insel_reg, edge_sel_reg, logic_reg,
                                          rise_flag_reg, fall_flag_reg};
        DTD_OFF_WCTL:     o_reg_rdata <= {w_run_reg, w_single_reg, w_tout_reg, w_clk_reg,
                                          w_cap_mask_reg, w_tout_mask_reg, w_pin_reg};
        DTD_OFF_BINIT_LO: o_reg_rdata <= b_init_lo_reg;
        DTD_OFF_BINIT_HI: o_reg_rdata <= b_init_hi_reg;
        DTD_OFF_WINIT_LO: o_reg_rdata <= w_init_reg[7:0];
        DTD_OFF_WINIT_HI: o_reg_rdata <= w_init_reg[15:8];
        DTD_OFF_CAP_RISE: o_reg_rdata <= cap_rise_reg;
        DTD_OFF_CAP_FALL: o_reg_rdata <= cap_fall_reg;
        default:          o_reg_rdata <= DTD_RST_BYTE;
      endcase
    end
  end

  // pin and interrupt outputs
  assign o_byte_timer_out        = b_out_reg;
  assign o_word_timer_out        = w_out_reg;
  assign o_byte_timer_pin_select = b_pin_reg;
  assign o_word_timer_pin_select = w_pin_reg;
  assign o_timeout_irq = (b_tout_reg & b_tout_mask_reg) | (w_tout_reg & w_tout_mask_reg);
  assign o_capture_irq = (rise_flag_reg | fall_flag_reg) &
                         (b_cap_mask_reg | w_cap_mask_reg);

endmodule // dtd_timer_top

// [shared/dtd_pkg.sv]
// constants for the dual byte/word timer with demodulation capture
// assumes a cpu register file that reaches the timers in expanded bank d
package dtd_pkg;

  // register file geometry
  localparam int          DTD_GROUP_REGS   = 16;     // registers per working group
  localparam logic [3:0]  DTD_TIMER_BANK   = 4'hd;   // expanded bank holding the timers
  localparam logic [3:0]  DTD_MAIN_BANK    = 4'h0;   // plain register file bank
  localparam logic [7:0]  DTD_PORT_LAST    = 8'h03;  // last port register
  localparam logic [7:0]  DTD_GP_LAST      = 8'hef;  // last general-purpose register
  localparam logic [7:0]  DTD_CTRL_FIRST   = 8'hf0;  // first control/status register

  // region codes on o_region
  localparam logic [1:0]  DTD_RGN_PORT     = 2'h0;
  localparam logic [1:0]  DTD_RGN_GP       = 2'h1;
  localparam logic [1:0]  DTD_RGN_CTRL     = 2'h2;
  localparam logic [1:0]  DTD_RGN_TIMER    = 2'h3;

  // offsets inside the timer bank
  localparam logic [3:0]  DTD_OFF_BCTL     = 4'h0;   // byte_timer_control
  localparam logic [3:0]  DTD_OFF_SCTL     = 4'h1;   // shared_timer_control
  localparam logic [3:0]  DTD_OFF_WCTL     = 4'h2;   // word_timer_control
  localparam logic [3:0]  DTD_OFF_BINIT_LO = 4'h4;   // byte_timer_init_low
  localparam logic [3:0]  DTD_OFF_BINIT_HI = 4'h5;   // byte_timer_init_high
  localparam logic [3:0]  DTD_OFF_WINIT_LO = 4'h6;   // word timer initial value, low byte
  localparam logic [3:0]  DTD_OFF_WINIT_HI = 4'h7;   // word timer initial value, high byte
  localparam logic [3:0]  DTD_OFF_CAP_RISE = 4'h8;   // capture on rising edge
  localparam logic [3:0]  DTD_OFF_CAP_FALL = 4'h9;   // capture on falling edge

  // byte and word timer control field positions
  localparam int          DTD_B_RUN        = 7;
  localparam int          DTD_B_SINGLE     = 6;
  localparam int          DTD_B_TOUT       = 5;
  localparam int          DTD_B_CLK_HI     = 4;
  localparam int          DTD_B_CLK_LO     = 3;
  localparam int          DTD_B_CAP_MASK   = 2;
  localparam int          DTD_B_TOUT_MASK  = 1;
  localparam int          DTD_B_PIN        = 0;

  // shared control field positions
  localparam int          DTD_S_MODE       = 7;
  localparam int          DTD_S_INSEL      = 6;
  localparam int          DTD_S_EDGE_HI    = 5;
  localparam int          DTD_S_EDGE_LO    = 4;
  localparam int          DTD_S_LOGIC_HI   = 3;
  localparam int          DTD_S_LOGIC_LO   = 2;
  localparam int          DTD_S_RISE       = 1;
  localparam int          DTD_S_FALL       = 0;

  // edge select codes
  localparam logic [1:0]  DTD_EDGE_FALL    = 2'h0;
  localparam logic [1:0]  DTD_EDGE_RISE    = 2'h1;
  localparam logic [1:0]  DTD_EDGE_BOTH    = 2'h2;

  // reset values
  localparam logic [7:0]  DTD_RST_BYTE     = 8'h00;
  localparam logic [15:0] DTD_RST_WORD     = 16'h0000;
  localparam logic [2:0]  DTD_RST_PRESC    = 3'h0;

  // byte timer demodulation states
  typedef enum logic [1:0] {DTD_IDLE, DTD_ARMED, DTD_COUNT} dtd_demod_t;

endpackage

// [test/dtd_pin_src.sv]
// external modulated source on the demodulator pin
// assumes the bench calls burst while the timer is armed
module dtd_pin_src (
  // clock
  input  wire logic i_clk,
  // modulated pin, always driven
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pin = 1'b0;
  // rise, fall 20 later, rise 30 later, fall 30 later
  task automatic burst();
    int gaps [4] = '{1, 20, 30, 30};
    foreach (gaps[k]) begin
      repeat (gaps[k]) @(posedge i_clk);
      #2 o_pin = ~o_pin;
    end
    repeat (20) @(posedge i_clk);
  endtask
endmodule // dtd_pin_src

// [test/dtd_props.sv]
// assertions on the timer register port and flag outputs
// assumes a bind onto dtd_timer_top, one clock domain
module dtd_props import dtd_pkg::*; (
  // clock and resets
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_stop_recover,
  // register access
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_short_addr,
  input wire logic [7:0] i_register_pointer,
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_hit,
  input wire logic [1:0] o_region,
  // flag outputs
  input wire logic       o_byte_timer_pin_select,
  input wire logic       o_word_timer_pin_select,
  input wire logic       o_timeout_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // plain long-address write to one bank offset
  sequence s_wr(logic [3:0] off);
    i_reg_wr && o_reg_hit && !i_short_addr && !i_stop_recover && i_reg_addr[3:0] == off;
  endsequence
  a_bank_hit: assert property (
    !i_short_addr && i_register_pointer[3:0] == DTD_TIMER_BANK && i_reg_addr[7:4] == 4'h0
    |-> o_reg_hit) else $error("bank access missed");
  a_bank_miss: assert property (
    i_register_pointer[3:0] != DTD_TIMER_BANK |-> !o_reg_hit) else $error("stray hit");
  a_region_map: assert property (
    !o_reg_hit && !i_short_addr |-> o_region == (i_reg_addr <= DTD_PORT_LAST ? DTD_RGN_PORT
    : i_reg_addr <= DTD_GP_LAST ? DTD_RGN_GP : DTD_RGN_CTRL)) else $error("bad region");
  a_miss_zero: assert property (
    !o_reg_hit |=> o_reg_rdata == 8'h00) else $error("read data off bank");
  a_pin_copy: assert property (
    s_wr(DTD_OFF_BCTL) |=> o_byte_timer_pin_select == $past(i_reg_wdata[0]))
    else $error("pin select not written");
  a_tout_hold: assert property (
    $fell(o_timeout_irq) |-> $past(i_reg_wr && o_reg_hit || i_stop_recover || i_sys_rst))
    else $error("timeout dropped without write");
  a_recover_pin: assert property (
    i_stop_recover |=> !o_byte_timer_pin_select && !o_word_timer_pin_select)
    else $error("pin select kept on recovery");
  a_reset_clear: assert property (
    $fell(i_sys_rst) |-> o_reg_rdata == 8'h00 && !o_timeout_irq && !o_byte_timer_pin_select)
    else $error("outputs not cleared");
endmodule // dtd_props

bind dtd_timer_top dtd_props i_props (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_stop_recover(i_stop_recover),
  .i_reg_addr(i_reg_addr), .i_short_addr(i_short_addr),
  .i_register_pointer(i_register_pointer), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit), .o_region(o_region),
  .o_byte_timer_pin_select(o_byte_timer_pin_select),
  .o_word_timer_pin_select(o_word_timer_pin_select), .o_timeout_irq(o_timeout_irq));

// [test/dual_timer_demodulator_tb.sv]
// self-checking bench for the byte/word timer with demodulation
// assumes dtd_timer_top, the dtd_props bind and the dtd_pin_src model
module dual_timer_demodulator_tb import dtd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, recov, short_a, wr_en, pin_a, pin_b; // driven inputs
  logic       hit, bout, wout, tirq, cirq;                   // observed outputs
  logic [7:0] addr, ptr, wdata, rdata, d, r, f;              // register port
  logic [1:0] region;                                        // address region
  logic [7:0] mreg [16] = '{default: 8'h00};                 // model of bank d
  logic [7:0] rgn_a [4] = '{8'h03, 8'h04, 8'hef, 8'hf0};     // region edges
  int         n, miscompares = 0, samples_checked = 0;       // counts

  dtd_timer_top i_dtd_timer_top (
    .i_clk(clk), .i_sys_rst(rst), .i_stop_recover(recov), .i_reg_addr(addr),
    .i_short_addr(short_a), .i_register_pointer(ptr), .i_reg_wr(wr_en),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit), .o_region(region),
    .i_demod_pin_a(pin_a), .i_demod_pin_b(pin_b), .o_byte_timer_out(bout),
    .o_word_timer_out(wout), .o_byte_timer_pin_select(), .o_word_timer_pin_select(),
    .o_timeout_irq(tirq), .o_capture_irq(cirq));
  dtd_pin_src i_dtd_pin_src (.i_clk(clk), .o_pin(pin_a));

  always #10 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe; init registers tracked by the model
  task automatic wr(input logic [3:0] off, input logic [7:0] dat);
    @(posedge clk);
    #2 {addr, wdata, wr_en} = {4'h0, off, dat, 1'b1};
    if (off inside {[4:7]}) mreg[off] = dat;
    @(posedge clk);
    #2 wr_en = 1'b0;
  endtask
  // read data is registered one cycle after the address
  task automatic rd(input logic [3:0] off, output logic [7:0] dat);
    @(posedge clk);
    #2 addr = {4'h0, off};
    @(posedge clk);
    #2 dat = rdata;
  endtask
  // cycles until the chosen timer output changes, capped at 300
  task automatic gap(input bit w, output int cnt);
    logic v;
    v = w ? wout : bout;
    cnt = 0;
    while ((w ? wout : bout) === v && cnt < 300) begin
      @(posedge clk);
      #2 cnt++;
    end
  endtask
  task automatic stop_test();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: the tests need well under 20000 cycles
  initial begin
    #1_000_000;
    miscompares++;
    stop_test();
  end

  initial begin
    {clk, rst, recov, short_a, wr_en, addr, wdata, pin_b} = {5'b01000, 17'h00000};
    ptr = 8'h0d;
    n = $urandom(32'h5876);
    pin_b = n[0];
    repeat (10) @(posedge clk);
    #2 rst = 1'b0;
    // power-on values, then random init data and an unmapped write
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 16; k++) begin
        rd(k[3:0], d);
        chk("bank reg", d, mreg[k]);
      end
      for (int k = 4; k < 11; k++) wr(k[3:0], 8'($urandom));
      mreg[8] = 8'h00;
      mreg[9] = 8'h00;
    end
    // region decode outside the timer bank
    ptr = 8'h00;
    foreach (rgn_a[k]) begin
      @(posedge clk);
      #2 addr = rgn_a[k];
      #1 chk("region", region, rgn_a[k] < 4 ? DTD_RGN_PORT
             : rgn_a[k] < 8'hf0 ? DTD_RGN_GP : DTD_RGN_CTRL);
      chk("hit", hit, 0);
    end
    // working group 7 lands in general registers, group 0 in the bank
    @(posedge clk);
    #2 {short_a, ptr, addr} = {1'b1, 8'h7d, 8'h01};
    #1 chk("group 7", {hit, region}, {1'b0, DTD_RGN_GP});
    @(posedge clk);
    #2 ptr = 8'h0d;
    #1 chk("group 0", hit, 1);
    @(posedge clk);
    #2 short_a = 1'b0;
    // byte timer single pass, then modulo with alternating reloads
    wr(4, 8'h03);
    wr(5, 8'h05);
    wr(0, 8'h20);
    wr(0, 8'hc0);
    gap(0, n);
    chk("byte start", n < 300, 1);
    gap(0, n);
    chk("byte halt", n, 300);
    wr(0, 8'h00);
    rd(0, d);
    chk("w0 keeps flag", d[5], 1);
    wr(0, 8'h20);
    rd(0, d);
    chk("w1 clears flag", d[5], 0);
    wr(0, 8'h80);
    gap(0, n);
    gap(0, n);
    chk("high reload", n, 6);
    gap(0, n);
    chk("low reload", n, 4);
    wr(0, 8'h00);
    wr(0, 8'h20);
    // word timer period for each prescale code
    wr(6, 8'h04);
    wr(7, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(2, 8'h82 | 8'(c << 3));
      gap(1, n);
      gap(1, n);
      chk("word period", n, 5 << c);
      chk("timeout irq", tirq, 1);
      rd(2, d);
      chk("word runs", d[7], 1);
      wr(2, 8'h00);
      repeat (8) @(posedge clk);
      rd(2, d);
      chk("word stops", d[7], 0);
      wr(2, 8'h20);
      rd(2, d);
      chk("word flag", d[5], 0);
    end
    // word single pass: one terminal count, then halted with the flag up
    wr(2, 8'hc0);
    gap(1, n);
    chk("word single run", n, 5);
    gap(1, n);
    chk("word single halt", n, 300);
    rd(2, d);
    chk("word halted", d[7:5], 3'h3);
    // stop recovery keeps prescale, capture masks and the byte timeout mask, clears the rest
    wr(0, 8'h1f);
    wr(2, 8'h1f);
    @(posedge clk);
    #2 recov = 1'b1;
    @(posedge clk);
    #2 recov = 1'b0;
    rd(0, d);
    chk("byte kept", d, 8'h1e);
    rd(2, d);
    chk("word kept", d, 8'h1c);
    // demodulation for the fall, rise and both edge codes
    wr(4, 8'hff);
    wr(5, 8'hff);
    for (int c = 0; c < 3; c++) begin
      wr(0, 8'h00);
      wr(1, 8'h83 | 8'(c << 4));
      wr(0, 8'h84);
      i_dtd_pin_src.burst();
      rd(1, d);
      chk("rise flag", d[1], c != 0);
      chk("fall flag", d[0], c != 1);
      chk("capture irq", cirq, 1);
    end
    rd(8, r);
    rd(9, f);
    chk("capture gap", 8'(f - r), 30);
    repeat (300) @(posedge clk);
    rd(0, d);
    chk("no wrap timeout", d[5], 0);
    wr(0, 8'h00);
    stop_test();
  end
endmodule // dual_timer_demodulator_tb
